// [slot_builder_pkg.sv]
package slot_builder_pkg;

	// slot and frame timebase
	localparam logic [3:0] LAST_SLOT = 4'he;
	localparam logic [11:0] SYNC_GAP_CHIPS = 12'h100;

	// packet-channel control slot at spreading factor 512
	localparam int PKT_SLOT_BITS = 10;
	localparam logic [3:0] CCC_ESTOP = 4'hf;
	localparam logic [3:0] CCC_SOM = 4'ha;
	localparam logic [1:0] SYM_ONES = 2'h3;

	// common pilot: 20 bits per slot, symbol A = 1+j is 11, -A is 00
	localparam int PILOT_SLOT_BITS = 20;
	localparam logic [19:0] COMMON_PILOT_CHANNEL_ANT1 = 20'hf_ffff;
	localparam logic [19:0] COMMON_PILOT_CHANNEL_ANT2 = 20'hc_3c3c;

	// broadcast channel: 18 data bits after the sync-code gap
	localparam logic [4:0] BCAST_BITS = 5'h12;
	localparam logic [4:0] BCAST_TAIL_POS = 5'h10;
	localparam logic [4:0] BCAST_HEAD_END = 5'h02;

	// secondary common control slot formats
	localparam logic [4:0] SCC_FMT_MAX = 5'h11;
	localparam logic [4:0] SCC_FMT_WIDE = 5'h08;
	localparam logic [4:0] SCC_FMT_LONG_PILOT = 5'h0c;
	localparam logic [10:0] SCC_BASE_BITS = 11'h014;
	localparam logic [10:0] SCC_PILOT_SHORT = 11'h008;
	localparam logic [10:0] SCC_PILOT_LONG = 11'h010;
	localparam logic [10:0] SCC_FORMAT_COMBO_INDICATOR_SHORT = 11'h002;
	localparam logic [10:0] SCC_FORMAT_COMBO_INDICATOR_LONG = 11'h008;
	localparam logic [2:0] SCC_K_WIDE_BIAS = 3'h2;

	// per-slot pilot columns, slot 0 in the top two bits
	localparam logic [29:0] PILOT_COL1 = 30'h312f_9da0;
	localparam logic [29:0] PILOT_COL3 = 30'h2918_2dcf;
	localparam logic [29:0] PILOT_COL5 = 30'h3e76_8312;
	localparam logic [29:0] PILOT_COL7 = 30'h20b7_3e91;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_START_LEN = 8'h04;
	localparam logic [7:0] REG_SCC_FMT = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_SCPICH0 = 8'h14;
	localparam logic [7:0] REG_SCPICH1 = 8'h18;
	localparam logic [7:0] REG_SCC_FORMAT_COMBO_INDICATOR = 8'h1c;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic bit_value;
		logic dtx;
		logic valid;
	} lane_type;

	typedef struct packed {
		logic scc_format_combo_indicator_used;
		logic bcast_space_time_diversity;
		logic tx_diversity;
	} ctrl_type;

	typedef struct packed {
		logic preamble_done;
		logic estop;
	} cmd_type;

	typedef struct packed {
		logic secondary_scramble;
		logic [7:0] code_index;
	} scpich_cfg_type;

	typedef struct packed {
		logic [7:0] frames_left;
		logic [1:0] zero;
		logic estop_pending;
		logic in_window;
		logic [3:0] slot;
	} status_type;

	typedef enum logic [3:0] {
		SCC_IDLE = 4'h1,
		SCC_FORMAT_COMBO_INDICATOR = 4'h2,
		SCC_DATA = 4'h4,
		SCC_PILOT = 4'h8
	} scc_state_type;

	function automatic logic [1:0] col_sym(input logic [29:0] col,
		input logic [3:0] idx);
		logic [29:0] s;
		s = col << {idx, 1'b0};
		return s[29:28];
	endfunction

endpackage

// [slot_serializer.sv]
`timescale 1ns/1ps
module slot_serializer #(
	parameter int WIDTH = 10
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_bits,
	input wire logic [WIDTH-1:0] load_dtx,
	input wire logic req,
	output slot_builder_pkg::lane_type lane
);
	localparam int CW = $clog2(WIDTH + 1);

	logic [WIDTH-1:0] shreg;
	logic [WIDTH-1:0] dmask;
	logic [CW-1:0] left;

	// a new slot always wins; leftovers of a short slot are dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= '0;
			dmask <= '0;
			left <= '0;
		end else if (load) begin
			shreg <= load_bits;
			dmask <= load_dtx;
			left <= CW'(WIDTH);
		end else if (req && left != '0) begin
			shreg <= shreg << 1;
			dmask <= dmask << 1;
			left <= left - CW'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lane <= '0;
		end else begin
			lane.valid <= !load && req && left != '0;
			lane.bit_value <= shreg[WIDTH-1];
			lane.dtx <= dmask[WIDTH-1];
		end
	end
endmodule

// [dl_control_slot_builder.sv]
`timescale 1ns/1ps
// Functional notes
// - packet control slot: 512 spreading, 2 power, 0 format, 4 command, 4 pilot
// - packet control pilot uses the four-bit antenna-1 dedicated pattern
// - command field carries a pattern only on request, else empty
// - emergency stop puts 1111 in the command field
// - emergency stop held back during the start-message window
// - start-of-message 1010 sent in every frame of that window
// - common pilot: fixed 30 kbps, spreading 256, fixed symbols only
// - antenna-2 pilot sequence only when any channel uses diversity; here only ctrl.tx_diversity turns it on, broadcast diversity alone does not
// - pilot symbol is 1+j; antenna 2 uses it or its negation
// - each secondary pilot has code index and scrambling choice
// - broadcast slot holds only data bits at 30 kbps, spreading 256
// - broadcast output blanked for first 256 chips of each slot
// - even-slot tail pairs with next head; slot 14 tail plain
// - sync codes modulated +1 when diversity on, -1 when off
// - secondary control spreading equals 256 over two to the k
// - secondary slots 20 to 1280 bits, fifteen slots a frame
// - eighteen formats; pilot 0/8/16, format field 0/2/8, rest data
// - secondary control with or without format field, per config
// - reserved but unused format field is left empty
// - pilot symbols outside sync words are all 11
module dl_control_slot_builder (
	input wire logic ref_clk,
	input wire logic rst_n,
	input slot_builder_pkg::bus_req_type bus,
	output logic [31:0] rdata,
	input wire logic slot_tick,
	input wire logic chip_tick,
	output logic [3:0] slot,
	input wire logic [1:0] tpc_bits,
	input wire logic pkt_req,
	output slot_builder_pkg::lane_type pkt_lane,
	input wire logic pilot_req,
	output slot_builder_pkg::lane_type pilot_ant1,
	output slot_builder_pkg::lane_type pilot_ant2,
	output logic pilot_ant2_on,
	output slot_builder_pkg::scpich_cfg_type scpich0_cfg,
	output slot_builder_pkg::scpich_cfg_type scpich1_cfg,
	input wire logic bcast_req,
	input wire logic bcast_data,
	input wire logic bcast_data_valid,
	output logic bcast_data_ready,
	output slot_builder_pkg::lane_type bcast_lane,
	output logic bcast_space_time_diversity_pair,
	output logic bcast_space_time_diversity_plain,
	output logic bcast_blank,
	output logic sync_mod_positive,
	input wire logic scc_req,
	input wire logic scc_data,
	input wire logic scc_data_valid,
	output logic scc_data_ready,
	output slot_builder_pkg::lane_type scc_lane,
	output logic [2:0] scc_spreading_log2
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	slot_builder_pkg::ctrl_type ctrl;
	slot_builder_pkg::cmd_type cmd;
	slot_builder_pkg::status_type status;
	slot_builder_pkg::scc_state_type scc_state;
	logic [7:0] start_len;
	logic [7:0] frames_left;
	logic [4:0] scc_fmt;
	logic [7:0] scc_format_combo_indicator;
	logic [11:0] chip;
	logic [3:0] next_slot;
	logic frame_tick;
	logic estop_pending;
	logic in_window;
	logic [3:0] pkt_ccc;
	logic pkt_ccc_on;
	logic [4:0] bc_pos;
	logic bc_take;
	logic [10:0] scc_total;
	logic [10:0] scc_npilot;
	logic [10:0] scc_ntfci;
	logic [10:0] scc_ndata;
	logic [10:0] fpos;
	logic scc_emit;
	logic scc_bit;
	logic [1:0] scc_sym;
	logic wr_ctrl;

	assign wr_ctrl = bus.wr && bus.addr == slot_builder_pkg::REG_CTRL;
	assign cmd = slot_builder_pkg::cmd_type'(bus.wdata[1:0]);

	// register writes; unknown offsets are ignored
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
			start_len <= '0;
			scc_fmt <= '0;
			scc_format_combo_indicator <= '0;
			scpich0_cfg <= '0;
			scpich1_cfg <= '0;
		end else if (bus.wr) begin
			unique case (bus.addr)
				slot_builder_pkg::REG_CTRL: ctrl <= bus.wdata[2:0];
				slot_builder_pkg::REG_START_LEN: start_len <= bus.wdata[7:0];
				slot_builder_pkg::REG_SCC_FMT: begin
					// illegal format codes leave the old format in place
					if (bus.wdata[4:0] <= slot_builder_pkg::SCC_FMT_MAX) begin
						scc_fmt <= bus.wdata[4:0];
					end
				end
				slot_builder_pkg::REG_SCPICH0: scpich0_cfg <= bus.wdata[8:0];
				slot_builder_pkg::REG_SCPICH1: scpich1_cfg <= bus.wdata[8:0];
				slot_builder_pkg::REG_SCC_FORMAT_COMBO_INDICATOR: scc_format_combo_indicator <= bus.wdata[7:0];
				default: begin
				end
			endcase
		end
	end

	assign status = '{frames_left: frames_left, zero: 2'h0,
		estop_pending: estop_pending, in_window: in_window, slot: slot};

	// read data stand in the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				slot_builder_pkg::REG_CTRL: rdata <= {29'h0000_0000, ctrl};
				slot_builder_pkg::REG_START_LEN: rdata <= {24'h00_0000, start_len};
				slot_builder_pkg::REG_SCC_FMT: rdata <= {27'h000_0000, scc_fmt};
				slot_builder_pkg::REG_STATUS: rdata <= {16'h0000, status};
				slot_builder_pkg::REG_SCPICH0: rdata <= {23'h00_0000, scpich0_cfg};
				slot_builder_pkg::REG_SCPICH1: rdata <= {23'h00_0000, scpich1_cfg};
				slot_builder_pkg::REG_SCC_FORMAT_COMBO_INDICATOR: rdata <= {24'h00_0000, scc_format_combo_indicator};
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// timebase: fifteen slots a frame
	assign next_slot = (slot == slot_builder_pkg::LAST_SLOT) ? 4'h0 : slot + 4'h1;
	assign frame_tick = slot_tick && slot == slot_builder_pkg::LAST_SLOT;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot <= slot_builder_pkg::LAST_SLOT;
		end else if (slot_tick) begin
			slot <= next_slot;
		end
	end

	// sync-code gap at the head of every slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chip <= '0;
			bcast_blank <= 1'b1;
		end else if (slot_tick) begin
			chip <= '0;
			bcast_blank <= 1'b1;
		end else if (chip_tick && bcast_blank) begin
			chip <= chip + 12'h001;
			bcast_blank <= chip != slot_builder_pkg::SYNC_GAP_CHIPS - 12'h001;
		end
	end

	// window counts whole frame boundaries after the preamble
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frames_left <= '0;
		end else if (bus.wr && bus.addr == slot_builder_pkg::REG_CMD &&
			cmd.preamble_done) begin
			frames_left <= start_len;
		end else if (frame_tick && frames_left != 8'h00) begin
			frames_left <= frames_left - 8'h01;
		end
	end
	// the boundary tick already loads a slot of the next frame
	assign in_window = frames_left != 8'h00 &&
		!(frame_tick && frames_left == 8'h01);

	// a request in the same cycle as the send survives; the set wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			estop_pending <= 1'b0;
		end else if (bus.wr && bus.addr == slot_builder_pkg::REG_CMD &&
			cmd.estop) begin
			estop_pending <= 1'b1;
		end else if (slot_tick && !in_window) begin
			estop_pending <= 1'b0;
		end
	end

	// pattern only on request, otherwise the field is empty
	always_comb begin
		pkt_ccc = slot_builder_pkg::CCC_ESTOP;
		pkt_ccc_on = estop_pending;
		if (in_window) begin
			pkt_ccc = slot_builder_pkg::CCC_SOM;
			pkt_ccc_on = 1'b1;
		end
	end

	// 2 power, 4 command, 4 pilot bits every slot
	// power bits, then command, then pilot
	slot_serializer #(
		.WIDTH(slot_builder_pkg::PKT_SLOT_BITS)
	) u_pkt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(slot_tick),
		.load_bits({tpc_bits, pkt_ccc, slot_builder_pkg::SYM_ONES,
			slot_builder_pkg::col_sym(slot_builder_pkg::PILOT_COL1, next_slot)}),
		.load_dtx({2'h0, {4{!pkt_ccc_on}}, 4'h0}),
		.req(pkt_req),
		.lane(pkt_lane)
	);

	// antenna 1 all A, antenna 2 mixes A and -A
	slot_serializer #(
		.WIDTH(slot_builder_pkg::PILOT_SLOT_BITS)
	) u_pilot1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(slot_tick),
		.load_bits(slot_builder_pkg::COMMON_PILOT_CHANNEL_ANT1),
		.load_dtx(20'h0_0000),
		.req(pilot_req),
		.lane(pilot_ant1)
	);

	// antenna 2 silent without diversity in the cell
	slot_serializer #(
		.WIDTH(slot_builder_pkg::PILOT_SLOT_BITS)
	) u_pilot2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(slot_tick),
		.load_bits(slot_builder_pkg::COMMON_PILOT_CHANNEL_ANT2),
		.load_dtx({20{!ctrl.tx_diversity}}),
		.req(pilot_req),
		.lane(pilot_ant2)
	);
	assign pilot_ant2_on = ctrl.tx_diversity;

	// sync modulation sign follows the diversity setting
	assign sync_mod_positive = ctrl.bcast_space_time_diversity;

	// data bits only, taken after the gap
	assign bc_take = bcast_req && !bcast_blank && !slot_tick &&
		bc_pos < slot_builder_pkg::BCAST_BITS && bcast_data_valid;
	assign bcast_data_ready = bc_take;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bc_pos <= '0;
			bcast_lane <= '0;
			bcast_space_time_diversity_pair <= 1'b0;
			bcast_space_time_diversity_plain <= 1'b0;
		end else begin
			if (slot_tick) begin
				bc_pos <= '0;
			end else if (bc_take) begin
				bc_pos <= bc_pos + 5'h01;
			end
			bcast_lane.valid <= bc_take;
			bcast_lane.bit_value <= bcast_data;
			bcast_lane.dtx <= 1'b0;
			// pairing only when software enables it
			// even tail with odd head; slot 14 tail plain
			bcast_space_time_diversity_pair <= bc_take && ctrl.bcast_space_time_diversity && (slot[0] ?
				bc_pos < slot_builder_pkg::BCAST_HEAD_END :
				(bc_pos >= slot_builder_pkg::BCAST_TAIL_POS &&
				slot != slot_builder_pkg::LAST_SLOT));
			bcast_space_time_diversity_plain <= bc_take && ctrl.bcast_space_time_diversity &&
				slot == slot_builder_pkg::LAST_SLOT &&
				bc_pos >= slot_builder_pkg::BCAST_TAIL_POS;
		end
	end

	// k from format, spreading factor is 256 shifted down by k
	// pilot 0/8/16 and format field 0/2/8 by format
	always_comb begin
		if (scc_fmt < slot_builder_pkg::SCC_FMT_WIDE) begin
			scc_spreading_log2 = {2'h0, scc_fmt[2]};
			scc_ntfci = scc_fmt[1] ? slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR_SHORT : 11'h000;
		end else begin
			scc_spreading_log2 = scc_fmt[3:1] - slot_builder_pkg::SCC_K_WIDE_BIAS;
			scc_ntfci = slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR_LONG;
		end
		scc_npilot = !scc_fmt[0] ? 11'h000 :
			(scc_fmt < slot_builder_pkg::SCC_FMT_LONG_PILOT) ?
			slot_builder_pkg::SCC_PILOT_SHORT : slot_builder_pkg::SCC_PILOT_LONG;
		// 20 bits doubling per step of k
		scc_total = slot_builder_pkg::SCC_BASE_BITS << scc_spreading_log2;
		scc_ndata = scc_total - scc_npilot - scc_ntfci;
	end

	// even symbols and sync-word gaps are 11
	always_comb begin
		scc_sym = slot_builder_pkg::SYM_ONES;
		if (fpos[1]) begin
			unique case (fpos[3:2])
				2'h0: scc_sym = slot_builder_pkg::col_sym(
					slot_builder_pkg::PILOT_COL1, slot);
				2'h1: scc_sym = slot_builder_pkg::col_sym(
					slot_builder_pkg::PILOT_COL3, slot);
				2'h2: scc_sym = slot_builder_pkg::col_sym(
					slot_builder_pkg::PILOT_COL5, slot);
				2'h3: scc_sym = slot_builder_pkg::col_sym(
					slot_builder_pkg::PILOT_COL7, slot);
			endcase
		end
	end

	always_comb begin
		scc_bit = 1'b0;
		unique case (scc_state)
			slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR: scc_bit = scc_format_combo_indicator[3'(scc_ntfci - fpos - 11'h001)];
			slot_builder_pkg::SCC_DATA: scc_bit = scc_data;
			slot_builder_pkg::SCC_PILOT: scc_bit = fpos[0] ? scc_sym[0] : scc_sym[1];
			slot_builder_pkg::SCC_IDLE: scc_bit = 1'b0;
		endcase
	end

	// upstream data waits until a data bit is pulled
	assign scc_data_ready = scc_req && !slot_tick &&
		scc_state == slot_builder_pkg::SCC_DATA;
	assign scc_emit = scc_req && !slot_tick &&
		scc_state != slot_builder_pkg::SCC_IDLE &&
		(scc_state != slot_builder_pkg::SCC_DATA || scc_data_valid);

	// format field, then data, then pilot
	// format field present or absent by format choice
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scc_state <= slot_builder_pkg::SCC_IDLE;
			fpos <= '0;
		end else if (slot_tick) begin
			fpos <= '0;
			scc_state <= (scc_ntfci != 11'h000) ? slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR :
				slot_builder_pkg::SCC_DATA;
		end else if (scc_emit) begin
			fpos <= fpos + 11'h001;
			unique case (scc_state)
				slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR: begin
					if (fpos == scc_ntfci - 11'h001) begin
						fpos <= '0;
						scc_state <= slot_builder_pkg::SCC_DATA;
					end
				end
				slot_builder_pkg::SCC_DATA: begin
					if (fpos == scc_ndata - 11'h001) begin
						fpos <= '0;
						scc_state <= (scc_npilot != 11'h000) ?
							slot_builder_pkg::SCC_PILOT : slot_builder_pkg::SCC_IDLE;
					end
				end
				slot_builder_pkg::SCC_PILOT: begin
					if (fpos == scc_npilot - 11'h001) begin
						scc_state <= slot_builder_pkg::SCC_IDLE;
					end
				end
				slot_builder_pkg::SCC_IDLE: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scc_lane <= '0;
		end else begin
			scc_lane.valid <= scc_emit;
			scc_lane.bit_value <= scc_bit;
			// unused format field goes out empty
			scc_lane.dtx <= scc_state == slot_builder_pkg::SCC_FORMAT_COMBO_INDICATOR &&
				!ctrl.scc_format_combo_indicator_used;
		end
	end

	chk_blank_gap: assert property (bcast_lane.valid |-> !$past(bcast_blank))
		else $error("broadcast bit sent inside sync gap");
	chk_estop_held: assert property (slot_tick && in_window |->
		pkt_ccc == slot_builder_pkg::CCC_SOM && pkt_ccc_on)
		else $error("stop sent inside start window");
	chk_som_window: assert property (slot_tick && in_window && estop_pending
		|=> estop_pending)
		else $error("stop request lost during start window");
	chk_estop_pattern: assert property (slot_tick && !in_window &&
		estop_pending |-> pkt_ccc == slot_builder_pkg::CCC_ESTOP && pkt_ccc_on)
		else $error("stop pattern wrong");
	chk_cmd_empty: assert property (slot_tick && !in_window && !estop_pending
		|=> u_pkt.dmask[7:4] == 4'hf)
		else $error("command field not empty");
	chk_sync_sign: assert property (wr_ctrl |=>
		sync_mod_positive == $past(bus.wdata[1]))
		else $error("sync sign does not follow setting");
	chk_space_time_diversity_plain: assert property (bcast_space_time_diversity_plain |->
		slot == slot_builder_pkg::LAST_SLOT && !bcast_space_time_diversity_pair)
		else $error("plain tail outside last slot");
	chk_bcast_limit: assert property (bc_pos <= slot_builder_pkg::BCAST_BITS)
		else $error("too many broadcast bits");
	chk_pilot_ant1: assert property (pilot_ant1.valid |->
		pilot_ant1.bit_value && !pilot_ant1.dtx)
		else $error("antenna-1 pilot not A");
	chk_scc_order: assert property (scc_state == slot_builder_pkg::SCC_PILOT
		&& !slot_tick |=> scc_state inside {slot_builder_pkg::SCC_PILOT,
		slot_builder_pkg::SCC_IDLE})
		else $error("secondary field order broken");

	cov_estop_sent: cover property (slot_tick && !in_window && estop_pending);
	cov_som_sent: cover property (slot_tick && in_window);
	cov_scc_pilot: cover property (scc_emit &&
		scc_state == slot_builder_pkg::SCC_PILOT);
	cov_bcast_plain: cover property (bcast_space_time_diversity_plain);
endmodule

// [far_side_model.sv]
`timescale 1ns/1ps
module far_side_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic bcast_data_ready,
	input wire logic scc_data_ready,
	output logic chip_tick,
	output logic bcast_data,
	output logic bcast_data_valid,
	output logic scc_data,
	output logic scc_data_valid
);
	logic bcast_bit;
	logic scc_bit;
	// chip strobe runs free, one chip a cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			chip_tick <= 1'b0;
		else
			chip_tick <= 1'b1;
	end
	// new bit only once the block took the last one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bcast_bit <= 1'b0;
			scc_bit <= 1'b1;
		end else begin
			if (bcast_data_valid && bcast_data_ready)
				bcast_bit <= ~bcast_bit;
			if (scc_data_valid && scc_data_ready)
				scc_bit <= ~scc_bit;
		end
	end
	assign bcast_data_valid = rst_n & ~stall;
	assign scc_data_valid = rst_n & ~stall;
	// stale value while not valid: the inverse of the next bit
	assign bcast_data = bcast_data_valid ? bcast_bit : ~bcast_bit;
	assign scc_data = scc_data_valid ? scc_bit : ~scc_bit;
endmodule

// [tb_dl_control_slot_builder.sv]
`timescale 1ns/1ps
module tb_dl_control_slot_builder;
	logic ref_clk, rst_n, slot_tick, chip_tick, pkt_req, pilot_req;
	logic bcast_req, bcast_data, bcast_data_valid, bcast_data_ready;
	logic scc_req, scc_data, scc_data_valid, scc_data_ready, stall;
	logic pilot_ant2_on, bcast_space_time_diversity_pair, bcast_space_time_diversity_plain, bcast_blank;
	logic sync_mod_positive;
	logic [1:0] tpc_bits;
	logic [2:0] scc_spreading_log2;
	logic [3:0] slot;
	logic [31:0] rdata, got, gdtx, pairs, plains, q;
	slot_builder_pkg::bus_req_type bus;
	slot_builder_pkg::lane_type pkt_lane, pilot_ant1, pilot_ant2;
	slot_builder_pkg::lane_type bcast_lane, scc_lane, sel;
	slot_builder_pkg::scpich_cfg_type scpich0_cfg, scpich1_cfg;
	int errors, checks_done, cnt;

	dl_control_slot_builder dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.bus(bus), .rdata(rdata), .slot_tick(slot_tick),
		.chip_tick(chip_tick), .slot(slot), .tpc_bits(tpc_bits),
		.pkt_req(pkt_req), .pkt_lane(pkt_lane), .pilot_req(pilot_req),
		.pilot_ant1(pilot_ant1), .pilot_ant2(pilot_ant2),
		.pilot_ant2_on(pilot_ant2_on), .scpich0_cfg(scpich0_cfg),
		.scpich1_cfg(scpich1_cfg), .bcast_req(bcast_req),
		.bcast_data(bcast_data), .bcast_data_valid(bcast_data_valid),
		.bcast_data_ready(bcast_data_ready), .bcast_lane(bcast_lane),
		.bcast_space_time_diversity_pair(bcast_space_time_diversity_pair),
		.bcast_space_time_diversity_plain(bcast_space_time_diversity_plain), .bcast_blank(bcast_blank),
		.sync_mod_positive(sync_mod_positive), .scc_req(scc_req),
		.scc_data(scc_data), .scc_data_valid(scc_data_valid),
		.scc_data_ready(scc_data_ready), .scc_lane(scc_lane),
		.scc_spreading_log2(scc_spreading_log2));

	far_side_model far_u (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
		.bcast_data_ready(bcast_data_ready),
		.scc_data_ready(scc_data_ready), .chip_tick(chip_tick),
		.bcast_data(bcast_data), .bcast_data_valid(bcast_data_valid),
		.scc_data(scc_data), .scc_data_valid(scc_data_valid));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		bus <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge ref_clk);
		bus <= '0;
		#1 q = rdata;
	endtask

	task automatic tick();
		@(posedge ref_clk);
		slot_tick <= 1'b1;
		@(posedge ref_clk);
		slot_tick <= 1'b0;
		#1;
	endtask

	// one request cycle, lane sampled once its edge has landed
	task automatic pull(input int ch);
		@(posedge ref_clk);
		pkt_req <= (ch == 0);
		pilot_req <= (ch == 1 || ch == 4);
		bcast_req <= (ch == 2);
		scc_req <= (ch == 3);
		@(posedge ref_clk);
		{pkt_req, pilot_req, bcast_req, scc_req} <= 4'h0;
		#1;
	endtask

	task automatic grab(input int ch, input int n);
		got = '0;
		gdtx = '0;
		pairs = '0;
		plains = '0;
		cnt = 0;
		for (int i = 0; i < n; i++) begin
			pull(ch);
			case (ch)
				0: sel = pkt_lane;
				1: sel = pilot_ant1;
				2: sel = bcast_lane;
				3: sel = scc_lane;
				default: sel = pilot_ant2;
			endcase
			if (sel.valid === 1'b1) begin
				got = {got[30:0], sel.bit_value};
				gdtx = {gdtx[30:0], sel.dtx};
				pairs[cnt] = bcast_space_time_diversity_pair;
				plains[cnt] = bcast_space_time_diversity_plain;
				cnt++;
			end
		end
	endtask

	task automatic t_regs();
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4));
			chk(q, (i == 4) ? 32'h0000_000e : 32'h0000_0000);
		end
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20);
		chk(q, 32'h0000_0000);
		wr(slot_builder_pkg::REG_CTRL, 32'hffff_ffff);
		rd(slot_builder_pkg::REG_CTRL);
		chk(q, 32'h0000_0007);
		wr(slot_builder_pkg::REG_SCPICH0, 32'h0000_01ab);
		wr(slot_builder_pkg::REG_SCPICH1, 32'h0000_0055);
		rd(slot_builder_pkg::REG_SCPICH0);
		chk(q, 32'h0000_01ab);
		chk(scpich0_cfg, 9'h1ab);
		chk(scpich1_cfg, 9'h055);
		$display("register test done");
	endtask

	task automatic t_pkt();
		int s;
		tpc_bits <= 2'b10;
		tick();
		s = slot;
		grab(0, 11);
		chk(cnt, 10);
		chk(got[9:8], 2'b10);
		chk(gdtx[7:4], 4'hf);
		chk(got[3:2], 2'b11);
		chk(got[1:0], slot_builder_pkg::PILOT_COL1[29 - 2 * s -: 2]);
		wr(slot_builder_pkg::REG_CMD, 32'h0000_0001);
		tick();
		grab(0, 10);
		chk({gdtx[7:4], got[7:4]}, 8'h0f);
		tick();
		grab(0, 10);
		chk(gdtx[7:4], 4'hf);
		$display("packet control test done");
	endtask

	task automatic t_window();
		wr(slot_builder_pkg::REG_START_LEN, 32'h0000_0001);
		wr(slot_builder_pkg::REG_CMD, 32'h0000_0002);
		wr(slot_builder_pkg::REG_CMD, 32'h0000_0001);
		tick();
		grab(0, 10);
		chk({gdtx[7:4], got[7:4]}, 8'h0a);
		rd(slot_builder_pkg::REG_STATUS);
		chk(q[5:4], 2'b11);
		repeat (11) tick();
		grab(0, 10);
		chk({gdtx[7:4], got[7:4]}, 8'h0a);
		tick();
		grab(0, 10);
		chk({gdtx[7:4], got[7:4]}, 8'h0f);
		$display("start window test done");
	endtask

	task automatic t_pilot();
		wr(slot_builder_pkg::REG_CTRL, 32'h0000_0003);
		chk({sync_mod_positive, pilot_ant2_on}, 2'b11);
		tick();
		grab(1, 21);
		chk({cnt[7:0], got[19:0]}, {8'd20, 20'hf_ffff});
		tick();
		grab(4, 20);
		chk({gdtx[19:0], got[19:0]}, {20'h0, slot_builder_pkg::COMMON_PILOT_CHANNEL_ANT2});
		wr(slot_builder_pkg::REG_CTRL, 32'h0000_0000);
		chk({sync_mod_positive, pilot_ant2_on}, 2'b00);
		tick();
		grab(4, 20);
		chk(gdtx[19:0], 20'hf_ffff);
		$display("common pilot test done");
	endtask

	task automatic bcast_slot();
		int w;
		logic [31:0] pw;
		tick();
		pull(2);
		chk({bcast_blank, bcast_lane.valid}, 2'b10);
		w = 3;
		while (bcast_blank === 1'b1 && w < 300) begin
			@(posedge ref_clk);
			w++;
		end
		chk(w inside {[254:260]}, 1'b1);
		stall <= 1'b1;
		pull(2);
		chk(bcast_lane.valid, 1'b0);
		stall <= 1'b0;
		grab(2, 19);
		chk(cnt, 18);
		chk(got[17:0], 18'h1_5555);
		pw = slot[0] ? 32'h0000_0003 : 32'h0003_0000;
		chk(pairs, (slot == 4'he) ? 0 : pw);
		chk(plains, (slot == 4'he) ? 32'h0003_0000 : 0);
	endtask

	task automatic t_bcast();
		wr(slot_builder_pkg::REG_CTRL, 32'h0000_0002);
		while (slot !== 4'hd)
			tick();
		bcast_slot();
		bcast_slot();
		bcast_slot();
		$display("broadcast test done");
	endtask

	task automatic t_scc();
		for (int f = 0; f < 18; f++) begin
			wr(slot_builder_pkg::REG_SCC_FMT, 32'(f));
			chk(scc_spreading_log2, (f < 8) ? f / 4 : f / 2 - 2);
		end
		wr(slot_builder_pkg::REG_SCC_FMT, 32'h0000_0012);
		rd(slot_builder_pkg::REG_SCC_FMT);
		chk(q, 32'h0000_0011);
		wr(slot_builder_pkg::REG_SCC_FMT, 32'h0000_0002);
		wr(slot_builder_pkg::REG_CTRL, 32'h0000_0000);
		tick();
		grab(3, 21);
		chk(cnt, 20);
		chk(gdtx[19:18], 2'b11);
		wr(slot_builder_pkg::REG_SCC_FORMAT_COMBO_INDICATOR, 32'h0000_0002);
		wr(slot_builder_pkg::REG_CTRL, 32'h0000_0004);
		tick();
		grab(3, 20);
		chk(gdtx[19:18], 2'b00);
		chk(got[19:18], 2'b10);
		wr(slot_builder_pkg::REG_SCC_FMT, 32'h0000_0001);
		tick();
		grab(3, 21);
		chk({cnt[7:0], gdtx[7:0]}, {8'd20, 8'h00});
		chk({got[7:6], got[3:2]}, 4'hf);
		chk({got[5:4], got[1:0]}, {slot_builder_pkg::PILOT_COL1[29 - 2 * slot -: 2],
			slot_builder_pkg::PILOT_COL3[29 - 2 * slot -: 2]});
		chk(got[19:8], 12'haaa);
		$display("secondary control test done");
	endtask

	// whole run is about 1500 cycles; this leaves wide margin
	initial begin
		#200000;
		errors++;
		results();
	end

	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		bus = '0;
		slot_tick = 1'b0;
		tpc_bits = 2'b00;
		stall = 1'b0;
		{pkt_req, pilot_req, bcast_req, scc_req} = 4'h0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_pkt();
		t_window();
		t_pilot();
		t_bcast();
		t_scc();
		results();
	end
endmodule
